/* inc/vpdp_pkg.sv */
// Constants, field layouts and carrier types of the valve process data packer
//
// Function
// - Upper lift: two, three; lower lift: one only
// - Command bits 0..2 each drive exactly one solenoid
// - Legacy status bits at 104 through 107
// - Legacy switch and sensor bits at 96..102
// - Legacy pressure 64, shafts at 32, 0
// - Newer layout replaces legacy from version two
// - Newer status bits at 120 through 123
// - Newer switch and sensor bits at 112..119
// - Newer pressure 80, shafts at 48, 16
// - Newer bit 0 teach, bit 1 invalid
// - Newer bit 2 flags service request
// - Newer bit 4 pressure ok, 5 fail
// - Newer monitor error byte at offset 8
// - Error masks 0x01..0x20 per solenoid on/off
package vpdp_pkg;

  // Image width of the cyclic input data
  localparam int IMG_W = 128;
  // Width of the command byte from the master
  localparam int CMD_W = 8;
  // Number of solenoids
  localparam int SOL_N = 3;
  // Width of one numeric image field
  localparam int WORD_W = 32;
  // Width of the monitor error byte and its used bits
  localparam int MON_W = 8;
  localparam int MON_USED_W = 6;

  // Command bit positions in the master output image
  localparam int CMD_MAIN = 0;
  localparam int CMD_UPPER = 1;
  localparam int CMD_LOWER = 2;

  // Legacy layout offsets
  localparam int LEG_STATUS = 104;
  localparam int LEG_EXT3 = 96;
  localparam int LEG_EXT4 = 97;
  localparam int LEG_POS1 = 98;
  localparam int LEG_POS2 = 99;
  localparam int LEG_LIFT = 100;
  localparam int LEG_POS3 = 101;
  localparam int LEG_POS4 = 102;
  localparam int LEG_PRESS = 64;
  localparam int LEG_SHAFT1 = 32;
  localparam int LEG_SHAFT2 = 0;

  // Newer layout offsets
  localparam int NEW_STATUS = 120;
  localparam int NEW_EXT3 = 112;
  localparam int NEW_SENS = 114;
  localparam int NEW_PRESS = 80;
  localparam int NEW_SHAFT1 = 48;
  localparam int NEW_SHAFT2 = 16;
  localparam int NEW_TEACH = 0;
  localparam int NEW_INVALID = 1;
  localparam int NEW_SERVICE = 2;
  localparam int NEW_PRESS_OK = 4;
  localparam int NEW_PRESS_FAIL = 5;
  localparam int NEW_MON = 8;

  // Monitor error masks
  localparam logic [7:0] MON_SOL1_ON = 8'h01;
  localparam logic [7:0] MON_SOL1_OFF = 8'h02;
  localparam logic [7:0] MON_SOL2_ON = 8'h04;
  localparam logic [7:0] MON_SOL2_OFF = 8'h08;
  localparam logic [7:0] MON_SOL3_ON = 8'h10;
  localparam logic [7:0] MON_SOL3_OFF = 8'h20;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FLAGS = 8'h04;
  localparam logic [7:0] REG_PRESS = 8'h08;
  localparam logic [7:0] REG_SHAFT1 = 8'h0C;
  localparam logic [7:0] REG_SHAFT2 = 8'h10;
  localparam logic [7:0] REG_MON = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;

  // Control register fields
  localparam int CTRL_NEW_LAYOUT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;

  // Flags register fields
  localparam int FLG_TEACH = 0;
  localparam int FLG_INVALID = 1;
  localparam int FLG_SERVICE = 2;
  localparam int FLG_PRESS_OK = 4;
  localparam int FLG_PRESS_FAIL = 5;
  localparam int FLG_EXT3 = 8;
  localparam int FLG_EXT4 = 9;
  localparam int FLG_SENS = 16;
  localparam logic [31:0] FLG_MASK = 32'h003F_0337;

  // Status register fields
  localparam int STS_FLAGS = 0;
  localparam int STS_VALVE = 4;
  localparam int STS_SOL = 8;
  localparam int STS_LAYOUT = 12;

  // Reset value of the data registers
  localparam logic [31:0] DATA_RST = 32'h0000_0000;

  // Decoded valve status, bit 0 closed upward to bit 3 lower lift
  typedef struct packed {
    logic lower_lift;
    logic upper_lift;
    logic open;
    logic closed;
  } vpdp_valve_s;

  // Calibrated sensor positions in image order
  typedef struct packed {
    logic pos5;
    logic pos4;
    logic pos3;
    logic lift;
    logic pos2;
    logic pos1;
  } vpdp_sens_s;

  // All software supplied fields of the image
  typedef struct packed {
    logic teach_active;
    logic teach_invalid;
    logic service_req;
    logic press_ok;
    logic press_fail;
    logic ext_sw3;
    logic ext_sw4;
    vpdp_sens_s sens;
    logic [31:0] air_pressure;
    logic [31:0] shaft_one;
    logic [31:0] shaft_two;
    logic [5:0] mon_err;
  } vpdp_fields_s;

endpackage : vpdp_pkg

/* hdl/vpdp_decode.sv */
// Valve status and solenoid command decoder
`timescale 1ns/1ps
`default_nettype none

module vpdp_decode (
  input wire logic position_flag_one_i,
  input wire logic position_flag_two_i,
  input wire logic position_flag_three_i,
  input wire logic position_flag_four_i,
  input wire logic [vpdp_pkg::CMD_W-1:0] cmd_i,
  output vpdp_pkg::vpdp_valve_s valve_o,
  output logic [vpdp_pkg::SOL_N-1:0] sol_o
);

  // Pattern match of the four position flags
  always_comb
  begin
    // Closed: one and three set, two and four clear
    valve_o.closed = position_flag_one_i & ~position_flag_two_i &
                     position_flag_three_i & ~position_flag_four_i;
    // Open: only four set
    valve_o.open = ~position_flag_one_i & ~position_flag_two_i &
                   ~position_flag_three_i & position_flag_four_i;
    // Upper seat lift: two and three set
    valve_o.upper_lift = ~position_flag_one_i & position_flag_two_i &
                         position_flag_three_i & ~position_flag_four_i;
    // Lower seat lift: only one set
    valve_o.lower_lift = position_flag_one_i & ~position_flag_two_i &
                         ~position_flag_three_i & ~position_flag_four_i;
  end

  // One command bit per solenoid, no cross coupling
  always_comb
  begin
    sol_o = '0;
    sol_o[0] = cmd_i[vpdp_pkg::CMD_MAIN];
    sol_o[1] = cmd_i[vpdp_pkg::CMD_UPPER];
    sol_o[2] = cmd_i[vpdp_pkg::CMD_LOWER];
  end

endmodule : vpdp_decode

`default_nettype wire

/* hdl/vpdp_packer.sv */
// Valve process data packer top with Wishbone register slave
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module vpdp_packer #(
  parameter int IMG_W = vpdp_pkg::IMG_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Position flag pins, asynchronous
  input wire logic position_flag_one_i,
  input wire logic position_flag_two_i,
  input wire logic position_flag_three_i,
  input wire logic position_flag_four_i,
  // Master output image and capture request from the link logic
  input wire logic [vpdp_pkg::CMD_W-1:0] pd_out_i,
  input wire logic pd_out_valid_i,
  input wire logic capture_i,
  // Solenoid drives and captured input image
  output logic [vpdp_pkg::SOL_N-1:0] solenoid_o,
  output logic [IMG_W-1:0] pd_in_o,
  output logic pd_in_valid_o
);

  // Refuse an image too narrow for the newer layout
  if (IMG_W < vpdp_pkg::NEW_STATUS + 4)
  begin : g_bad_width
    $error("vpdp_packer: IMG_W too small for the image layout");
  end

  // Synchroniser stages for the four position flag pins
  logic [3:0] flag_meta;
  logic [3:0] flag_sync;
  logic [3:0] pins;

  assign pins = {position_flag_four_i, position_flag_three_i,
                 position_flag_two_i, position_flag_one_i};

  // Two flops; only the second stage feeds logic
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flag_meta <= 4'h0;
      flag_sync <= 4'h0;
    end
    else
    begin
      flag_meta <= pins;
      flag_sync <= flag_meta;
    end
  end

  // Decoder outputs
  vpdp_pkg::vpdp_valve_s valve; // Decoded valve status
  logic [vpdp_pkg::SOL_N-1:0] sol_cmd; // Decoded solenoid drives

  // Status and command decoding
  vpdp_decode u_decode (
    .position_flag_one_i(flag_sync[0]),
    .position_flag_two_i(flag_sync[1]),
    .position_flag_three_i(flag_sync[2]),
    .position_flag_four_i(flag_sync[3]),
    .cmd_i(pd_out_i),
    .valve_o(valve),
    .sol_o(sol_cmd)
  );

  // Software register state
  logic [31:0] ctrl; // Layout select
  logic [31:0] flags; // Loose status bits
  logic [31:0] press; // Air pressure in bar
  logic [31:0] shaft1; // Shaft position one
  logic [31:0] shaft2; // Shaft position two
  logic [31:0] mon; // Monitor error byte
  logic [31:0] next_ctrl;
  logic [31:0] next_flags;
  logic [31:0] next_press;
  logic [31:0] next_shaft1;
  logic [31:0] next_shaft2;
  logic [31:0] next_mon;

  // Bus handshake state
  logic next_ack;
  logic [31:0] next_dat;
  logic [7:0] word_adr; // Word aligned byte address
  logic wr_take; // Write takes effect at this edge

  // Merge write data under the byte lane selects
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  assign word_adr = {wb_adr_i[7:2], 2'b00};
  assign wr_take = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  // Next values of the software registers
  always_comb
  begin
    next_ctrl = ctrl;
    next_flags = flags;
    next_press = press;
    next_shaft1 = shaft1;
    next_shaft2 = shaft2;
    next_mon = mon;
    // Write lands at the edge where the master sees ack
    if (wr_take)
    begin
      case (word_adr)
        vpdp_pkg::REG_CTRL:
        begin
          next_ctrl = merge(ctrl, wb_dat_i, wb_sel_i) &
                      32'h0000_0001;
        end
        vpdp_pkg::REG_FLAGS:
        begin
          next_flags = merge(flags, wb_dat_i, wb_sel_i) &
                       vpdp_pkg::FLG_MASK;
        end
        vpdp_pkg::REG_PRESS:
        begin
          next_press = merge(press, wb_dat_i, wb_sel_i);
        end
        vpdp_pkg::REG_SHAFT1:
        begin
          next_shaft1 = merge(shaft1, wb_dat_i, wb_sel_i);
        end
        vpdp_pkg::REG_SHAFT2:
        begin
          next_shaft2 = merge(shaft2, wb_dat_i, wb_sel_i);
        end
        vpdp_pkg::REG_MON:
        begin
          // Only the six defined error masks are kept
          next_mon = merge(mon, wb_dat_i, wb_sel_i) &
                     {24'h000000, vpdp_pkg::MON_SOL1_ON |
                      vpdp_pkg::MON_SOL1_OFF | vpdp_pkg::MON_SOL2_ON |
                      vpdp_pkg::MON_SOL2_OFF | vpdp_pkg::MON_SOL3_ON |
                      vpdp_pkg::MON_SOL3_OFF};
        end
        default:
        begin
          // Unmapped or read-only: write ignored
          next_ctrl = ctrl;
        end
      endcase
    end
  end

  // Register the software state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl <= vpdp_pkg::CTRL_RST;
      flags <= vpdp_pkg::DATA_RST;
      press <= vpdp_pkg::DATA_RST;
      shaft1 <= vpdp_pkg::DATA_RST;
      shaft2 <= vpdp_pkg::DATA_RST;
      mon <= vpdp_pkg::DATA_RST;
    end
    else
    begin
      ctrl <= next_ctrl;
      flags <= next_flags;
      press <= next_press;
      shaft1 <= next_shaft1;
      shaft2 <= next_shaft2;
      mon <= next_mon;
    end
  end

  // Ack and read data, answered one cycle after the strobe
  always_comb
  begin
    next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    next_dat = 32'h0000_0000;
    case (word_adr)
      vpdp_pkg::REG_CTRL:
      begin
        next_dat = ctrl;
      end
      vpdp_pkg::REG_FLAGS:
      begin
        next_dat = flags;
      end
      vpdp_pkg::REG_PRESS:
      begin
        next_dat = press;
      end
      vpdp_pkg::REG_SHAFT1:
      begin
        next_dat = shaft1;
      end
      vpdp_pkg::REG_SHAFT2:
      begin
        next_dat = shaft2;
      end
      vpdp_pkg::REG_MON:
      begin
        next_dat = mon;
      end
      vpdp_pkg::REG_STATUS:
      begin
        // Live pins, decoded status, drives and layout
        next_dat[vpdp_pkg::STS_FLAGS +: 4] = flag_sync;
        next_dat[vpdp_pkg::STS_VALVE +: 4] = valve;
        next_dat[vpdp_pkg::STS_SOL +: vpdp_pkg::SOL_N] = solenoid_o;
        next_dat[vpdp_pkg::STS_LAYOUT] = ctrl[vpdp_pkg::CTRL_NEW_LAYOUT];
      end
      default:
      begin
        // Unmapped reads return zero
        next_dat = 32'h0000_0000;
      end
    endcase
  end

  // Register the bus answer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // Field bundle gathered for the image
  vpdp_pkg::vpdp_fields_s fld;
  logic [IMG_W-1:0] img; // Image assembled this cycle
  logic [IMG_W-1:0] next_pd_in;
  logic next_pd_valid;
  logic [vpdp_pkg::SOL_N-1:0] next_sol;

  // Unpack register bits into named fields
  always_comb
  begin
    fld.teach_active = flags[vpdp_pkg::FLG_TEACH];
    fld.teach_invalid = flags[vpdp_pkg::FLG_INVALID];
    fld.service_req = flags[vpdp_pkg::FLG_SERVICE];
    fld.press_ok = flags[vpdp_pkg::FLG_PRESS_OK];
    fld.press_fail = flags[vpdp_pkg::FLG_PRESS_FAIL];
    fld.ext_sw3 = flags[vpdp_pkg::FLG_EXT3];
    fld.ext_sw4 = flags[vpdp_pkg::FLG_EXT4];
    fld.sens = flags[vpdp_pkg::FLG_SENS +: 6];
    fld.air_pressure = press;
    fld.shaft_one = shaft1;
    fld.shaft_two = shaft2;
    fld.mon_err = mon[vpdp_pkg::MON_USED_W-1:0];
  end

  // Assemble the image in the selected layout
  always_comb
  begin
    img = '0;
    if (ctrl[vpdp_pkg::CTRL_NEW_LAYOUT])
    begin
      img[vpdp_pkg::NEW_STATUS +: 4] = valve;
      img[vpdp_pkg::NEW_EXT3] = fld.ext_sw3;
      img[vpdp_pkg::NEW_EXT3 + 1] = fld.ext_sw4;
      img[vpdp_pkg::NEW_SENS +: 6] = fld.sens;
      img[vpdp_pkg::NEW_PRESS +: 32] = fld.air_pressure;
      img[vpdp_pkg::NEW_SHAFT1 +: 32] = fld.shaft_one;
      img[vpdp_pkg::NEW_SHAFT2 +: 32] = fld.shaft_two;
      img[vpdp_pkg::NEW_TEACH] = fld.teach_active;
      img[vpdp_pkg::NEW_INVALID] = fld.teach_invalid;
      img[vpdp_pkg::NEW_SERVICE] = fld.service_req;
      img[vpdp_pkg::NEW_PRESS_OK] = fld.press_ok;
      img[vpdp_pkg::NEW_PRESS_FAIL] = fld.press_fail;
      img[vpdp_pkg::NEW_MON +: vpdp_pkg::MON_W] =
        {2'b00, fld.mon_err};
    end
    else
    begin
      // Legacy layout, no teach, service or monitor fields
      img[vpdp_pkg::LEG_STATUS +: 4] = valve;
      img[vpdp_pkg::LEG_EXT3] = fld.ext_sw3;
      img[vpdp_pkg::LEG_EXT4] = fld.ext_sw4;
      img[vpdp_pkg::LEG_POS1] = fld.sens.pos1;
      img[vpdp_pkg::LEG_POS2] = fld.sens.pos2;
      img[vpdp_pkg::LEG_LIFT] = fld.sens.lift;
      img[vpdp_pkg::LEG_POS3] = fld.sens.pos3;
      img[vpdp_pkg::LEG_POS4] = fld.sens.pos4;
      img[vpdp_pkg::LEG_PRESS +: 32] = fld.air_pressure;
      img[vpdp_pkg::LEG_SHAFT1 +: 32] = fld.shaft_one;
      img[vpdp_pkg::LEG_SHAFT2 +: 32] = fld.shaft_two;
    end
  end

  // Next image, valid pulse and solenoid drives
  always_comb
  begin
    next_pd_in = pd_in_o;
    next_pd_valid = capture_i;
    next_sol = solenoid_o;
    // All fields taken at one edge so they agree
    if (capture_i)
    begin
      next_pd_in = img;
    end
    // New commands take effect only with a valid output image
    if (pd_out_valid_i)
    begin
      next_sol = sol_cmd;
    end
  end

  // Register the image and drives
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pd_in_o <= '0;
      pd_in_valid_o <= 1'b0;
      solenoid_o <= '0;
    end
    else
    begin
      pd_in_o <= next_pd_in;
      pd_in_valid_o <= next_pd_valid;
      solenoid_o <= next_sol;
    end
  end

endmodule : vpdp_packer

`default_nettype wire

/* tb/vpdp_packer_checker.sv */
// Concurrent checks on the ports of the valve process data packer
`timescale 1ns/1ps
`default_nettype none

module vpdp_packer_checker #(
  parameter int IMG_W = 128
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [7:0] pd_out_i,
  input wire logic pd_out_valid_i,
  input wire logic capture_i,
  input wire logic [2:0] solenoid_o,
  input wire logic [IMG_W-1:0] pd_in_o,
  input wire logic pd_in_valid_o
);
  // One clock domain, reset quiets every check
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // A fresh bus request that has not been answered yet
  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  // Answer one cycle later, gone the cycle after
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_ack_after_req: assert property (s_bus_req |=> s_ack_pulse)
    else $error("bus answer missing or too long");
  a_ack_needs_req: assert property
    (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("bus answer without request");
  a_valid_on_capture: assert property (capture_i |=> pd_in_valid_o)
    else $error("image valid missing after capture");
  a_valid_no_capture: assert property (!capture_i |=> !pd_in_valid_o)
    else $error("image valid without capture");
  a_image_holds: assert property (!capture_i |=> $stable(pd_in_o))
    else $error("image changed without capture");
  a_sol_load: assert property
    (pd_out_valid_i |=> solenoid_o == $past(pd_out_i[2:0]))
    else $error("solenoid drive differs from command");
  a_sol_hold: assert property (!pd_out_valid_i |=> $stable(solenoid_o))
    else $error("solenoid drive changed without command");
  a_spare_zero: assert property
    (pd_in_valid_o |-> pd_in_o[IMG_W-1:124] == '0)
    else $error("spare image bits not zero");
  a_status_onehot: assert property
    (pd_in_valid_o |-> $onehot0(pd_in_o[123:120]))
    else $error("more than one valve status set");
endmodule : vpdp_packer_checker

bind vpdp_packer vpdp_packer_checker #(.IMG_W(IMG_W)) vpdp_packer_checker_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .pd_out_i(pd_out_i), .pd_out_valid_i(pd_out_valid_i),
  .capture_i(capture_i), .solenoid_o(solenoid_o), .pd_in_o(pd_in_o),
  .pd_in_valid_o(pd_in_valid_o)
);

`default_nettype wire

/* tb/vpdp_master_model.sv */
// Behavioural link master: solenoid commands and image capture requests
`timescale 1ns/1ps
`default_nettype none

module vpdp_master_model (
  input wire logic clk_i,
  output logic [7:0] pd_out_o,
  output logic pd_out_valid_o,
  output logic capture_o
);
  // Idle at time zero
  initial
  begin
    pd_out_o = 8'h00;
    pd_out_valid_o = 1'b0;
    capture_o = 1'b0;
  end

  // Command byte held valid for hold cycles, slow masters use more
  task automatic send_cmd(input logic [2:0] sol, input int hold);
    @(posedge clk_i);
    pd_out_o <= {5'h00, sol};
    pd_out_valid_o <= 1'b1;
    repeat (hold) @(posedge clk_i);
    pd_out_valid_o <= 1'b0;
    // Released byte no longer shows the command
    pd_out_o <= ~{5'h00, sol};
  endtask : send_cmd

  // Capture request held for n back to back cycles
  task automatic capture(input int n);
    @(posedge clk_i);
    capture_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    capture_o <= 1'b0;
  endtask : capture
endmodule : vpdp_master_model

`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench of the valve process data packer
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); \
    end \
  end

module testbench;
  // One table row: pins, command, master hold, expected valve status
  typedef struct packed {
    logic [3:0] flags;
    logic [2:0] cmd;
    logic [1:0] hold;
    logic [3:0] exp;
  } vpdp_row_s;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [3:0] flags = 4'h0; // Pins, bit 0 is flag one
  logic [7:0] pd_out;
  logic pd_out_valid;
  logic capture;
  logic [2:0] solenoid_o;
  logic [127:0] pd_in_o;
  logic pd_in_valid_o;
  logic [31:0] rd;
  int fails = 0;
  int checks_done = 0;
  // Closed, open, upper, lower, then patterns that match nothing
  vpdp_row_s rows [8] = '{
    '{4'h5, 3'h1, 2'h1, 4'h1}, '{4'h8, 3'h2, 2'h3, 4'h2},
    '{4'h6, 3'h4, 2'h1, 4'h4}, '{4'h1, 3'h0, 2'h2, 4'h8},
    '{4'h0, 3'h1, 2'h1, 4'h0}, '{4'hF, 3'h2, 2'h1, 4'h0},
    '{4'h7, 3'h4, 2'h1, 4'h0}, '{4'h9, 3'h0, 2'h1, 4'h0}};

  vpdp_packer vpdp_packer_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .position_flag_one_i(flags[0]), .position_flag_two_i(flags[1]),
    .position_flag_three_i(flags[2]), .position_flag_four_i(flags[3]),
    .pd_out_i(pd_out), .pd_out_valid_i(pd_out_valid), .capture_i(capture),
    .solenoid_o(solenoid_o), .pd_in_o(pd_in_o), .pd_in_valid_o(pd_in_valid_o)
  );

  vpdp_master_model vpdp_master_model_inst (
    .clk_i(clk_i), .pd_out_o(pd_out), .pd_out_valid_o(pd_out_valid),
    .capture_o(capture)
  );

  // 25 MHz clock
  initial
  begin
    forever #20 clk_i = ~clk_i;
  end

  // Verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb_xfer(input logic we, input logic [7:0] adr,
                         input logic [31:0] wd, output logic [31:0] rdat);
    int n;
    n = 0;
    // Request starts just after a rising edge
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= wd;
    // Look at ack mid-cycle, where it has settled
    @(negedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      @(negedge clk_i);
      n++;
    end
    // Read data stands with ack, as the next edge will see it
    rdat = wb_dat_o;
    if (n == 20)
    begin
      fails++;
      summarize();
    end
    // Edge at which ack is sampled high; release after it
    @(posedge clk_i);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer

  // Capture the image and see the valid pulse
  task automatic grab(input int n);
    vpdp_master_model_inst.capture(n);
    // Valid pulse of the last capture cycle, seen settled
    @(negedge clk_i);
    `CHK(pd_in_valid_o, 1'b1);
  endtask : grab

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge clk_i);
    fails++;
    summarize();
  end

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Reset state, newer layout selected
    wb_xfer(1'b0, 8'h00, 32'h0, rd);
    `CHK(rd, 32'h0000_0001);
    `CHK(pd_in_o, 128'h0);
    $display("reset test done");
    // Table of pin patterns and commands
    foreach (rows[i])
    begin
      flags <= rows[i].flags;
      vpdp_master_model_inst.send_cmd(rows[i].cmd, int'(rows[i].hold));
      repeat (3) @(posedge clk_i);
      grab(1);
      `CHK(pd_in_o[123:120], rows[i].exp);
      `CHK(solenoid_o, rows[i].cmd);
      wb_xfer(1'b0, 8'h18, 32'h0, rd);
      `CHK(rd[7:0], {rows[i].exp, rows[i].flags});
    end
    $display("table test done");
    // Full newer image with distinct field values
    wb_xfer(1'b1, 8'h04, 32'h0025_0125, rd);
    wb_xfer(1'b1, 8'h08, 32'hA5C3_0F1E, rd);
    wb_xfer(1'b1, 8'h0C, 32'h1234_5678, rd);
    wb_xfer(1'b1, 8'h10, 32'h9ABC_DEF0, rd);
    wb_xfer(1'b1, 8'h14, 32'h0000_0005, rd);
    flags <= 4'h5;
    repeat (3) @(posedge clk_i);
    grab(2);
    `CHK(pd_in_o, {8'h01, 8'h95, 96'hA5C30F1E_12345678_9ABCDEF0, 16'h0525});
    $display("newer image test done");
    // Legacy image of the same state
    wb_xfer(1'b1, 8'h00, 32'h0, rd);
    grab(1);
    `CHK(pd_in_o, {24'h1, 8'h15, 96'hA5C30F1E_12345678_9ABCDEF0});
    wb_xfer(1'b1, 8'h00, 32'h1, rd);
    grab(1);
    `CHK(pd_in_o[123:120], 4'h1);
    $display("legacy image test done");
    // Every monitor error mask on its own
    for (int k = 0; k < 6; k++)
    begin
      wb_xfer(1'b1, 8'h14, 32'h1 << k, rd);
      grab(1);
      `CHK(pd_in_o[15:8], 8'h01 << k);
    end
    $display("monitor test done");
    // Read-only and unmapped places
    wb_xfer(1'b1, 8'h18, 32'hFFFF_FFFF, rd);
    wb_xfer(1'b0, 8'h18, 32'h0, rd);
    `CHK(rd[12:0], {1'b1, 1'b0, 3'h0, 4'h1, 4'h5});
    wb_xfer(1'b0, 8'hFC, 32'h0, rd);
    `CHK(rd, 32'h0);
    $display("refusal test done");
    summarize();
  end
endmodule : testbench

`default_nettype wire
